// *** design/cmr_message_ram.sv ***
// message ram with allocation, user addresses and sec/ded ecc
// What this block does
// - 2 KB message ram holds tx, rx and tx event objects.
// - event objects first at lowest address, only when event store enabled.
// - transmit queue objects follow, only when queue enabled.
// - fifos 1 to 31 follow in order, each with own depth and payload.
// - per-fifo user address points to next object, computed by hardware.
// - object data area sized from its own payload select.
// - each word protected by seven parity bits, sec/ded.
// - ecc enabled: encode on write, decode on read.
// - ecc disabled: store software parity, return data unchanged.
// - encoder computes parity from 32 data bits, stores with data.
// - decoder corrects single errors and detects double errors.
// - word 0: base id 10-0, extended id 28-11, bit twelve at 29.
// - tx word 1: sequence 31-9, esi 8, fdf, brs, rtr, ide, dlc.
// - gateway mode transmits esi as object esi or error passive.
// - payload from third word, byte 0 in low bits.
// - rx word 1 carries filter index in bits 15-11.
// - rx timestamp word present only when fifo timestamp enabled.
// - rx brs and esi reflect received frame.
// - event object copies id, sequence, flags; timestamp if enabled.
// - unimplemented object bits are undefined on read.
// - only whole 32-bit words are written.
// - word aligned: two low address bits ignored.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cmr_message_ram #(
	parameter int NFIFO = cmr_pkg::NFIFO
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// avalon-mm slave
	input wire logic [11:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// protocol engine port
	input wire logic i_eng_req,
	input wire logic i_eng_we,
	input wire logic [8:0] i_eng_word,
	input wire logic [31:0] i_eng_wdata,
	input wire logic i_error_passive,
	output logic o_eng_ack,
	output logic [31:0] o_eng_rdata,
	output logic o_tx_esi,
	// fifo pointer advance from fifo logic
	input wire logic [4:0] i_fifo_sel,
	input wire logic i_fifo_step,
	input wire logic i_fifo_clear
);
	localparam int W = cmr_pkg::DATA_W + cmr_pkg::PAR_W;
	typedef logic [cmr_pkg::IDX_W-1:0] cmr_idx_t;
	typedef enum logic [1:0] {IDLE, RD, DONE} cmr_state_e;
	typedef struct packed {
		cmr_state_e st;
		logic host;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [31:0] ecc;
		logic sec;
		logic ded;
		cmr_idx_t err_idx;
		logic [cmr_pkg::CFG_W-1:0] tef_cfg;
		logic [cmr_pkg::CFG_W-1:0] txq_cfg;
		logic [NFIFO-1:0][cmr_pkg::CFG_W-1:0] fcfg;
		logic [NFIFO-1:0][4:0] fidx;
		cmr_idx_t acc_idx;
		logic eng_ack;
		logic [31:0] eng_rdata;
	} cmr_state_s;
	cmr_state_s q_r, q_nxt;
	logic [W-1:0] mem_r [cmr_pkg::RAM_WORDS];
	logic mem_we;
	cmr_idx_t mem_widx;
	logic [W-1:0] mem_wdata;
	logic [W-1:0] mem_rword;
	cmr_idx_t base [NFIFO+1];
	cmr_idx_t osz [NFIFO+1];
	// the engine holds req through the ack edge, so a req still up while ack is out is the old one
	logic eng_go;
	logic host_wr_go;
	assign eng_go = i_eng_req & ~q_r.eng_ack;
	// host write lands in an idle cycle with the engine quiet, the edge that sees waitrequest low
	assign host_wr_go = i_write & ~eng_go & (q_r.st == IDLE);

	////////////////////////////////////////////////////////////////
	// hamming over 38 positions plus overall parity
	function automatic logic [5:0] cmr_syn(input logic [31:0] d, input logic [5:0] p);
		logic [5:0] s;
		int pos;
		int k;
		s = p;
		pos = 1;
		for (k = 0; k < 32; k++) begin
			pos = pos + 1;
			while ((pos & (pos - 1)) == 0) pos = pos + 1;
			if (d[k]) s = s ^ pos[5:0];
		end
		return s;
	endfunction

	function automatic logic [31:0] cmr_flip(input logic [31:0] d, input logic [5:0] s);
		logic [31:0] r;
		int pos;
		int k;
		r = d;
		pos = 1;
		for (k = 0; k < 32; k++) begin
			pos = pos + 1;
			while ((pos & (pos - 1)) == 0) pos = pos + 1;
			if (pos[5:0] == s) r[k] = ~r[k];
		end
		return r;
	endfunction

	function automatic logic [6:0] cmr_enc(input logic [31:0] d);
		logic [5:0] p;
		p = cmr_syn(d, 6'h00);
		return {^{d, p}, p};
	endfunction

	// objects in a queue: stored depth-1 plus one, widened first so 32 deep does not wrap to 0
	function automatic cmr_idx_t cmr_depth(input logic [cmr_pkg::CFG_W-1:0] c);
		return cmr_idx_t'(c[cmr_pkg::CFG_DEPTH_MSB:0]) + 9'h001;
	endfunction

	// object words: two header words, optional timestamp, payload
	function automatic cmr_idx_t cmr_objw(input logic [cmr_pkg::CFG_W-1:0] c, input logic hdr);
		logic [2:0] pl;
		cmr_idx_t n;
		pl = c[cmr_pkg::CFG_PL_MSB:cmr_pkg::CFG_PL_LSB];
		n = cmr_idx_t'(cmr_pkg::HDR_WORDS) + cmr_idx_t'(c[cmr_pkg::CFG_TS_BIT]);
		if (hdr) begin
			// payload 8,12,16,20,24,32,48,64 bytes
			unique case (pl)
				3'h0: n = n + 9'h002;
				3'h1: n = n + 9'h003;
				3'h2: n = n + 9'h004;
				3'h3: n = n + 9'h005;
				3'h4: n = n + 9'h006;
				3'h5: n = n + 9'h008;
				3'h6: n = n + 9'h00c;
				3'h7: n = n + 9'h010;
			endcase
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////
	// allocation: event queue, transmit queue, then fifo 1..31
	always_comb begin
		cmr_idx_t a;
		a = '0;
		if (q_r.ctrl[cmr_pkg::CTRL_TEF_EN]) begin
			a = a + cmr_objw(q_r.tef_cfg, 1'b0) * cmr_depth(q_r.tef_cfg);
		end
		osz[0] = cmr_objw(q_r.txq_cfg, 1'b1);
		base[0] = a;
		if (q_r.ctrl[cmr_pkg::CTRL_TXQ_EN]) begin
			a = a + osz[0] * cmr_depth(q_r.txq_cfg);
		end
		// no check for running past 2 KB: software must size the queues to fit
		for (int f = 1; f <= NFIFO - 1; f++) begin
			osz[f] = cmr_objw(q_r.fcfg[f], 1'b1);
			base[f] = a;
			a = a + osz[f] * cmr_depth(q_r.fcfg[f]);
		end
		osz[NFIFO] = '0;
		base[NFIFO] = a;
	end

	////////////////////////////////////////////////////////////////
	// ram read decode
	logic [31:0] rd_raw;
	logic [5:0] rd_syn;
	logic rd_ovr;
	logic [31:0] rd_fix;
	logic rd_sec;
	logic rd_ded;
	always_comb begin
		rd_raw = mem_rword[31:0];
		rd_syn = cmr_syn(rd_raw, mem_rword[37:32]);
		rd_ovr = ^mem_rword;
		rd_sec = 1'b0;
		rd_ded = 1'b0;
		rd_fix = rd_raw;
		if (q_r.ecc[cmr_pkg::ECC_EN_BIT]) begin
			// odd overall parity: one bit flipped; a zero syndrome means the overall bit itself
			if (rd_ovr) begin
				rd_sec = 1'b1;
				rd_fix = cmr_flip(rd_raw, rd_syn);
			// even overall parity with a syndrome: two bits, data left as read
			end else if (rd_syn != 6'h00) begin
				rd_ded = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// control and register bus
	always_comb begin
		logic ram_hit;
		cmr_idx_t widx;
		logic [31:0] wd;
		q_nxt = q_r;
		q_nxt.eng_ack = 1'b0;
		mem_we = 1'b0;
		mem_widx = '0;
		mem_wdata = '0;
		wd = i_writedata;
		ram_hit = i_address[11];
		widx = i_address[10:2];
		unique case (q_r.st)
			IDLE: begin
				// engine first; a host request waits behind it
				if (eng_go) begin
					q_nxt.host = 1'b0;
					q_nxt.acc_idx = i_eng_word;
					if (i_eng_we) begin
						mem_we = 1'b1;
						mem_widx = i_eng_word;
						wd = i_eng_wdata;
						q_nxt.eng_ack = 1'b1;
					end else begin
						q_nxt.st = RD;
					end
				end else if (i_write) begin
					// no wait state: the write lands at this edge, state stays idle
					if (ram_hit) begin
						// only a full word reaches the array
						mem_we = (i_byteenable == 4'hf);
						mem_widx = widx;
					end else if (i_address == cmr_pkg::REG_CTRL) begin
						q_nxt.ctrl = i_writedata;
					end else if (i_address == cmr_pkg::REG_ECC) begin
						q_nxt.ecc = i_writedata;
					end else if (i_address == cmr_pkg::REG_STAT) begin
						// write one to clear
						q_nxt.sec = q_r.sec & ~i_writedata[cmr_pkg::STAT_SEC];
						q_nxt.ded = q_r.ded & ~i_writedata[cmr_pkg::STAT_DED];
					end else if (q_r.ctrl[cmr_pkg::CTRL_CFG_MODE]) begin
						if (i_address == cmr_pkg::REG_TEFCFG) q_nxt.tef_cfg = i_writedata[cmr_pkg::CFG_W-1:0];
						if (i_address == cmr_pkg::REG_TXQCFG) q_nxt.txq_cfg = i_writedata[cmr_pkg::CFG_W-1:0];
						if (i_address[11:7] == cmr_pkg::REG_FIFOCFG[11:7]) begin
							q_nxt.fcfg[i_address[6:2]] = i_writedata[cmr_pkg::CFG_W-1:0];
						end
						q_nxt.fidx = '0;
					end
				end else if (i_read) begin
					q_nxt.host = 1'b1;
					q_nxt.acc_idx = widx;
					q_nxt.st = RD;
					q_nxt.rdata = '0;
					if (i_address == cmr_pkg::REG_CTRL) q_nxt.rdata = q_r.ctrl;
					if (i_address == cmr_pkg::REG_ECC) q_nxt.rdata = q_r.ecc;
					if (i_address == cmr_pkg::REG_STAT) q_nxt.rdata = {30'h0, q_r.ded, q_r.sec};
					if (i_address == cmr_pkg::REG_ERRADDR) q_nxt.rdata = {21'h0, q_r.err_idx, 2'h0};
					if (i_address == cmr_pkg::REG_TEFCFG) q_nxt.rdata = {23'h0, q_r.tef_cfg};
					if (i_address == cmr_pkg::REG_TXQCFG) q_nxt.rdata = {23'h0, q_r.txq_cfg};
					if (i_address[11:7] == cmr_pkg::REG_FIFOCFG[11:7]) begin
						q_nxt.rdata = {23'h0, q_r.fcfg[i_address[6:2]]};
					end
					if (i_address[11:7] == cmr_pkg::REG_UADDR[11:7]) begin
						q_nxt.rdata = {21'h0, 11'(base[i_address[6:2]] +
							osz[i_address[6:2]] * cmr_idx_t'(q_r.fidx[i_address[6:2]])) << 2}
							| {20'h0, cmr_pkg::RAM_BASE};
					end
				end
			end
			RD: begin
				// array read settles during this cycle; the answer is registered at its end
				q_nxt.st = q_r.host ? DONE : IDLE;
				if (q_r.host) begin
					if (i_address[11]) q_nxt.rdata = rd_fix;
				end else begin
					q_nxt.eng_rdata = rd_fix;
					q_nxt.eng_ack = 1'b1;
				end
				if ((rd_sec | rd_ded) & (q_r.host ? i_address[11] : 1'b1)) begin
					q_nxt.err_idx = q_r.acc_idx;
				end
			end
			DONE: q_nxt.st = IDLE;
			default: q_nxt.st = IDLE;
		endcase
		// flags set over clear: rise from decoder wins
		if (q_r.st == RD && (q_r.host ? i_address[11] : 1'b1)) begin
			q_nxt.sec = q_nxt.sec | rd_sec;
			q_nxt.ded = q_nxt.ded | rd_ded;
		end
		// clear wins over step when both come at once
		if (i_fifo_clear) begin
			q_nxt.fidx[i_fifo_sel] = '0;
		end else if (i_fifo_step) begin
			q_nxt.fidx[i_fifo_sel] = (q_r.fidx[i_fifo_sel] == q_r.fcfg[i_fifo_sel][cmr_pkg::CFG_DEPTH_MSB:0]) ?
				5'h00 : q_r.fidx[i_fifo_sel] + 5'h01;
		end
		if (q_r.ecc[cmr_pkg::ECC_EN_BIT]) begin
			mem_wdata = {cmr_enc(wd), wd};
		end else begin
			mem_wdata = {q_r.ecc[cmr_pkg::ECC_PAR_LSB+6:cmr_pkg::ECC_PAR_LSB], wd};
		end
	end

	////////////////////////////////////////////////////////////////
	// storage and registers; ram has no reset, contents survive
	always_ff @(posedge i_clock) begin
		if (mem_we) mem_r[mem_widx] <= mem_wdata;
	end
	assign mem_rword = mem_r[q_r.acc_idx];

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q_r <= '0;
			q_r.ctrl[cmr_pkg::CTRL_CFG_MODE] <= 1'b1;
			q_r.st <= IDLE;
		end else begin
			q_r <= q_nxt;
		end
	end

	// object fields pass through as words
	assign o_tx_esi = (q_r.ctrl[cmr_pkg::CTRL_GW_ESI] & q_r.eng_rdata[cmr_pkg::W1_ESI]) | i_error_passive;
	assign o_readdata = q_r.rdata;
	// reads take the array cycle and answer from done; writes answer at once unless the engine holds the array
	assign o_waitrequest = i_read ? (q_r.st != DONE) : (i_write & ~host_wr_go);
	assign o_eng_ack = q_r.eng_ack;
	assign o_eng_rdata = q_r.eng_rdata;
endmodule
`default_nettype wire

// *** design/cmr_pkg.sv ***
// constants for the message ram with ecc
package cmr_pkg;
	localparam int DATA_W = 32;
	localparam int PAR_W = 7;
	localparam int RAM_BYTES = 2048;
	localparam int RAM_WORDS = RAM_BYTES / 4;
	localparam int IDX_W = 9;
	localparam int NFIFO = 32;
	localparam int CFG_W = 9;
	// avalon register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_ECC = 12'h004;
	localparam logic [11:0] REG_STAT = 12'h008;
	localparam logic [11:0] REG_ERRADDR = 12'h00c;
	localparam logic [11:0] REG_TEFCFG = 12'h010;
	localparam logic [11:0] REG_TXQCFG = 12'h014;
	localparam logic [11:0] REG_FIFOCFG = 12'h080;
	localparam logic [11:0] REG_UADDR = 12'h100;
	localparam logic [11:0] RAM_BASE = 12'h800;
	// ctrl, ecc and status bits
	localparam int CTRL_TEF_EN = 0;
	localparam int CTRL_TXQ_EN = 1;
	localparam int CTRL_GW_ESI = 2;
	localparam int CTRL_CFG_MODE = 3;
	localparam int ECC_EN_BIT = 0;
	localparam int ECC_PAR_LSB = 8;
	localparam int STAT_SEC = 0;
	localparam int STAT_DED = 1;
	// fifo config field layout: depth-1 [4:0], payload select [7:5], timestamp [8]
	localparam int CFG_DEPTH_MSB = 4;
	localparam int CFG_PL_LSB = 5;
	localparam int CFG_PL_MSB = 7;
	localparam int CFG_TS_BIT = 8;
	localparam int HDR_WORDS = 2;
	// object word 0 and 1 fields
	localparam int W1_ESI = 8;
	localparam int W1_FILT_LSB = 11;
	localparam int W1_FILT_MSB = 15;
	localparam int W0_IMPL_MSB = 29;
endpackage

// *** sim/cmr_properties.sv ***
// port timing checks of the message ram
`timescale 1ns/1ps
`default_nettype none
module cmr_properties (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// watched ports
	input wire logic i_read,
	input wire logic i_write,
	input wire logic i_eng_req,
	input wire logic i_eng_we,
	input wire logic i_error_passive,
	input wire logic o_waitrequest,
	input wire logic [31:0] o_readdata,
	input wire logic o_eng_ack,
	input wire logic [31:0] o_eng_rdata,
	input wire logic o_tx_esi
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	////////////////////////////////
	write_answer_a: assert property ($rose(i_write) && !i_eng_req |-> !o_waitrequest)
		else $error("host write not answered");
	read_two_step_a: assert property (i_read && !o_waitrequest |-> $past(i_read) && $past(o_waitrequest))
		else $error("host read answered too early");
	eng_write_ack_a: assert property ($rose(i_eng_req) && i_eng_we |-> ##[1:4] o_eng_ack)
		else $error("engine write not acknowledged");
	eng_read_ack_a: assert property ($rose(i_eng_req) && !i_eng_we |-> ##[1:5] o_eng_ack)
		else $error("engine read not acknowledged");
	esi_passive_a: assert property (i_error_passive |-> o_tx_esi)
		else $error("esi low while error passive");
	readdata_hold_a: assert property (!$past(i_read) |-> $stable(o_readdata))
		else $error("read data moved without a read");
	eng_rdata_hold_a: assert property (!$past(i_eng_req) |-> $stable(o_eng_rdata))
		else $error("engine data moved without a request");
	ack_cause_a: assert property (o_eng_ack |-> $past(i_eng_req))
		else $error("engine ack without request");
endmodule
bind cmr_message_ram cmr_properties i_cmr_properties (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_read(i_read),
	.i_write(i_write), .i_eng_req(i_eng_req), .i_eng_we(i_eng_we), .i_error_passive(i_error_passive),
	.o_waitrequest(o_waitrequest), .o_readdata(o_readdata), .o_eng_ack(o_eng_ack), .o_eng_rdata(o_eng_rdata),
	.o_tx_esi(o_tx_esi));
`default_nettype wire

// *** sim/cmr_engine_model.sv ***
// protocol engine stand-in on the engine word port
`timescale 1ns/1ps
`default_nettype none
module cmr_engine_model (
	// clock
	input wire logic i_clock,
	// answers from the ram
	input wire logic i_eng_ack,
	input wire logic [31:0] i_eng_rdata,
	// requests to the ram
	output logic o_req,
	output logic o_we,
	output logic [8:0] o_word,
	output logic [31:0] o_wdata
);
	initial begin
		o_req = 1'b0;
		o_we = 1'b0;
		o_word = 9'h000;
		o_wdata = 32'h0;
	end
	////////////////////////////////
	// request held until ack is seen; released word and data lines show their inverse, never the last value
	task access(input logic we, input logic [8:0] word, input logic [31:0] wd, input int lag,
		output logic [31:0] rd);
		repeat (lag) @(posedge i_clock);
		@(posedge i_clock);
		o_req <= 1'b1;
		o_we <= we;
		o_word <= word;
		o_wdata <= wd;
		do @(posedge i_clock); while (i_eng_ack !== 1'b1);
		rd = i_eng_rdata;
		o_req <= 1'b0;
		o_word <= ~word;
		o_wdata <= ~wd;
	endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench of the message ram
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [11:0] ra;
	logic rd_s = 1'b0, wr_s = 1'b0, ep = 1'b0, step = 1'b0, clr = 1'b0;
	logic [3:0] be = 4'hf;
	logic [4:0] fsel = 5'h01;
	logic [31:0] wd = 32'h0, r, d, base, s1, e_rd;
	logic req, we, wreq, ack, esi;
	logic [8:0] word;
	logic [31:0] ewd, rdata, erdata;
	int n_errors = 0, checked = 0, cycles = 0, i;
	int seed = 32'he8a95350;
	initial forever #12.5 i_clock = ~i_clock;
	cmr_message_ram i_cmr_message_ram (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_address(adr), .i_read(rd_s),
		.i_write(wr_s), .i_byteenable(be), .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wreq),
		.i_eng_req(req), .i_eng_we(we), .i_eng_word(word), .i_eng_wdata(ewd), .i_error_passive(ep),
		.o_eng_ack(ack), .o_eng_rdata(erdata), .o_tx_esi(esi), .i_fifo_sel(fsel), .i_fifo_step(step),
		.i_fifo_clear(clr));
	cmr_engine_model i_cmr_engine_model (.i_clock(i_clock), .i_eng_ack(ack), .i_eng_rdata(erdata), .o_req(req),
		.o_we(we), .o_word(word), .o_wdata(ewd));
	////////////////////////////////
	task close_out;
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			close_out();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] b);
		@(posedge i_clock);
		rd_s <= !w;
		wr_s <= w;
		adr <= a;
		wd <= v;
		be <= b;
		// held until the edge that samples waitrequest low; read data taken there
		do @(posedge i_clock); while (wreq !== 1'b0);
		r = rdata;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task rd(input logic [11:0] a);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask
	task pulse(input logic c);
		@(posedge i_clock);
		step <= !c;
		clr <= c;
		@(posedge i_clock);
		step <= 1'b0;
		clr <= 1'b0;
	endtask
	// first fifo object sits right after the event objects; event payload is empty
	function automatic logic [31:0] tef_end(input int depth, input int ts);
		return 32'h800 + depth * 4 * (cmr_pkg::HDR_WORDS + ts);
	endfunction
	// bytes of one object: header, optional timestamp, payload 8..24 by 4, then 32, 48, 64
	function automatic logic [31:0] obj_bytes(input int pl, input int ts);
		int pay;
		pay = (pl < 5) ? 8 + 4 * pl : 32 + 16 * (pl - 5);
		return 4 * (cmr_pkg::HDR_WORDS + ts) + pay;
	endfunction
	////////////////////////////////
	initial begin
		repeat (20) @(posedge i_clock);
		i_rst_b <= 1'b1;
		rd(cmr_pkg::REG_CTRL);
		chk("ctrl reset", 32'h8, r);
		rd(12'h7f0);
		chk("unmapped", 32'h0, r);
		bus(1'b1, cmr_pkg::REG_TEFCFG, 32'h102, 4'hf);
		bus(1'b1, cmr_pkg::REG_TXQCFG, 32'h1f, 4'hf);
		bus(1'b1, cmr_pkg::REG_FIFOCFG + 12'h004, 32'h3, 4'hf);
		bus(1'b1, cmr_pkg::REG_FIFOCFG + 12'h008, 32'h1e0, 4'hf);
		bus(1'b1, cmr_pkg::REG_CTRL, 32'h9, 4'hf);
		bus(1'b1, cmr_pkg::REG_CTRL, 32'h1, 4'hf);
		bus(1'b1, cmr_pkg::REG_TEFCFG, 32'h0, 4'hf);
		base = tef_end(3, 1);
		rd(cmr_pkg::REG_UADDR + 12'h004);
		chk("fifo1 address", base, r);
		rd(cmr_pkg::REG_UADDR + 12'h008);
		chk("fifo2 address", base + 4 * obj_bytes(0, 0), r);
		rd(cmr_pkg::REG_UADDR + 12'h00c);
		chk("fifo3 address", base + 4 * obj_bytes(0, 0) + obj_bytes(7, 1), r);
		pulse(1'b0);
		rd(cmr_pkg::REG_UADDR + 12'h004);
		s1 = r;
		chk("fifo1 step", base + obj_bytes(0, 0), s1);
		for (i = 0; i < 3; i++) pulse(1'b0);
		rd(cmr_pkg::REG_UADDR + 12'h004);
		chk("fifo1 wrap", base, r);
		pulse(1'b0);
		pulse(1'b1);
		rd(cmr_pkg::REG_UADDR + 12'h004);
		chk("fifo1 clear", base, r);
		bus(1'b1, cmr_pkg::REG_ECC, 32'h1, 4'hf);
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			ra = 12'h800 | 12'($random(seed));
			bus(1'b1, ra, d, 4'hf);
			bus(1'b1, ra, ~d, 4'h3);
			rd(ra ^ 12'h003);
			chk("ram word", d, r);
		end
		bus(1'b1, cmr_pkg::REG_ECC, 32'h0, 4'hf);
		bus(1'b1, 12'h810, 32'h1, 4'hf);
		bus(1'b1, 12'h814, 32'h3, 4'hf);
		rd(12'h810);
		chk("raw read", 32'h1, r);
		bus(1'b1, cmr_pkg::REG_ECC, 32'h1, 4'hf);
		rd(12'h810);
		chk("corrected", 32'h0, r);
		rd(cmr_pkg::REG_STAT);
		chk("single flag", 32'h1, r);
		bus(1'b1, cmr_pkg::REG_STAT, 32'h3, 4'hf);
		rd(12'h814);
		rd(cmr_pkg::REG_STAT);
		chk("double flag", 32'h2, r);
		d = $random(seed);
		fork
			i_cmr_engine_model.access(1'b1, 9'h005, d, 0, e_rd);
			bus(1'b1, 12'h818, ~d, 4'hf);
		join
		rd(12'h814);
		rd(12'h814);
		rd(12'h800 + 12'h014);
		chk("engine to host", d, r);
		i_cmr_engine_model.access(1'b0, 9'h006, 32'h0, 2, e_rd);
		chk("host to engine", ~d, e_rd);
		bus(1'b1, cmr_pkg::REG_CTRL, 32'h5, 4'hf);
		i_cmr_engine_model.access(1'b1, 9'h007, 32'h100, 1, e_rd);
		i_cmr_engine_model.access(1'b0, 9'h007, 32'h0, 0, e_rd);
		chk("gateway esi", 32'h1, {31'h0, esi});
		i_cmr_engine_model.access(1'b1, 9'h007, 32'h0, 0, e_rd);
		i_cmr_engine_model.access(1'b0, 9'h007, 32'h0, 0, e_rd);
		chk("esi clear", 32'h0, {31'h0, esi});
		@(posedge i_clock);
		ep <= 1'b1;
		@(negedge i_clock);
		chk("esi passive", 32'h1, {31'h0, esi});
		close_out();
	end
endmodule
`default_nettype wire
